// >>> dv/lbp_host_model.sv
// host side model driving the register port and run level
`timescale 1ns/1ns
`default_nettype none
module lbp_host_model (
    // clock and read answer
    input  wire logic        clk,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid,
    // register requests and run level
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             switch_run_enable
);
    // quiet bus at time zero, run off
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        switch_run_enable = 1'b0;
    end
    // one write; idle lines then carry the inverse so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask : wr
    // one read; answer is taken one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = reg_rvalid;
        d = reg_rdata;
    endtask : rd
    // one level change stands for a group packet reaching all devices at once;
    // returns after the edge that samples the new level, so phase has reacted
    task automatic run(input logic r);
        @(posedge clk);
        switch_run_enable <= r;
        @(posedge clk);
        #1;
    endtask : run
endmodule : lbp_host_model
`default_nettype wire

// >>> dv/lbp_pwm_assertions.sv
// port checks for the led bypass pwm top
`timescale 1ns/1ns
`default_nettype none
module lbp_pwm_assertions
    import lbp_pkg::*;
(
    // watched ports
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        switch_run_enable,
    input wire logic [15:0] switch_config,
    input wire logic        config_write_refused,
    input wire logic        led4_lit,
    input wire logic        led5_lit,
    input wire logic        bypass4_closed,
    input wire logic        bypass5_closed,
    input wire logic [11:0] phase_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // config writes, and those that arrive while running
    wire cfg_wr  = reg_wr && (reg_addr == LBP_ADDR_SWITCH_CONFIG);
    wire cfg_bad = cfg_wr && switch_run_enable;
    // run rises and is still high one edge later
    sequence s_run_start;
        $rose(switch_run_enable) ##1 switch_run_enable;
    endsequence
    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without a read");
    cfg_write_a: assert property (cfg_wr && !switch_run_enable |=> switch_config == $past(reg_wdata))
        else $error("config write lost while stopped");
    cfg_refuse_a: assert property (cfg_bad |=> config_write_refused && $stable(switch_config))
        else $error("config changed while running");
    refuse_cause_a: assert property (config_write_refused |-> $past(cfg_bad))
        else $error("refusal without a bad write");
    phase_hold_a: assert property (!switch_run_enable |=> phase_count == 12'h000 && !led4_lit && !led5_lit)
        else $error("phase or led active while stopped");
    phase_start_a: assert property (s_run_start |-> phase_count == 12'h001)
        else $error("phase did not restart from zero");
    phase_wrap_a: assert property (phase_count == 12'hFFE |=> phase_count == 12'h000)
        else $error("period is not 4095 steps");
    bypass_inverse_a: assert property (bypass4_closed != led4_lit && bypass5_closed != led5_lit)
        else $error("bypass not inverse of lit");
endmodule : lbp_pwm_assertions
bind lbp_pwm_top lbp_pwm_assertions lbp_pwm_assertions_inst (.clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .switch_run_enable, .switch_config,
    .config_write_refused, .led4_lit, .led5_lit, .bypass4_closed, .bypass5_closed, .phase_count);
`default_nettype wire

// >>> dv/led_bypass_pwm_channels_tb.sv
// self-checking bench for the led bypass pwm channels
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, sn); end end
module led_bypass_pwm_channels_tb;
    import lbp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, switch_config, d;
    logic reg_wr, reg_rd, reg_rvalid, switch_run_enable, config_write_refused, v;
    logic led4_lit, led5_lit, bypass4_closed, bypass5_closed;
    logic [11:0] phase_count;
    int miscompares = 0, n_compared = 0, cycles = 0;
    integer c4, c5;    // four-state so an unknown lit level shows up in the counts
    lbp_host_model lbp_host_model_inst (.clk, .reg_rdata, .reg_rvalid, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .switch_run_enable);
    lbp_pwm_top lbp_pwm_top_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reg_rvalid, .switch_run_enable, .switch_config, .config_write_refused,
        .led4_lit, .led5_lit, .bypass4_closed, .bypass5_closed, .phase_count);
    // 100 ns clock
    always #50 clk = ~clk;
    // cut a hang well past the five pwm periods the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            summarize();
        end
    end
    // read one register and compare the answer
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
        lbp_host_model_inst.rd(a, d, v);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, d)
    endtask : chk_rd
    // count lit cycles of both channels over one full period
    task automatic count_lit();
        c4 = 0;
        c5 = 0;
        repeat (3) @(posedge clk);
        repeat (4095) begin
            @(posedge clk);
            #1;
            c4 += led4_lit;
            c5 += led5_lit;
        end
    endtask : count_lit
    // dimming and config registers read back their reset values
    task automatic t_reset();
        chk_rd(LBP_ADDR_CH4_DIMMING, 16'h0000);
        chk_rd(LBP_ADDR_CH5_DIMMING, 16'h0000);
        chk_rd(LBP_ADDR_SWITCH_CONFIG, LBP_CONFIG_RESET);
        `CHK("bypass4", 1'b1, bypass4_closed)
        `CHK("bypass5", 1'b1, bypass5_closed)
        `CHK("phase", 12'h000, phase_count)
        $display("test reset done");
    endtask : t_reset
    // field packing, unused bits, unmapped place
    task automatic t_regs();
        lbp_host_model_inst.wr(LBP_ADDR_CH4_DIMMING, 16'hF800);
        lbp_host_model_inst.wr(8'h30, 16'h1234);
        chk_rd(LBP_ADDR_CH4_DIMMING, 16'h1800);
        lbp_host_model_inst.wr(LBP_ADDR_CH5_DIMMING, 16'h0ABC);
        chk_rd(LBP_ADDR_CH5_DIMMING, 16'h0ABC);
        chk_rd(8'h30, 16'h0000);
        $display("test regs done");
    endtask : t_regs
    // config taken while stopped, refused while running
    task automatic t_config();
        lbp_host_model_inst.wr(LBP_ADDR_SWITCH_CONFIG, 16'hA5C3);
        `CHK("config", 16'hA5C3, switch_config)
        lbp_host_model_inst.run(1'b1);
        lbp_host_model_inst.wr(LBP_ADDR_SWITCH_CONFIG, 16'h1111);
        `CHK("refused", 1'b1, config_write_refused)
        `CHK("config", 16'hA5C3, switch_config)
        lbp_host_model_inst.run(1'b0);
        `CHK("phase", 12'h000, phase_count)
        $display("test config done");
    endtask : t_config
    // duty ends: one step, full, off
    task automatic t_duty();
        lbp_host_model_inst.wr(LBP_ADDR_CH4_DIMMING, 16'h0001);
        lbp_host_model_inst.wr(LBP_ADDR_CH5_DIMMING, 16'h0FFF);
        lbp_host_model_inst.run(1'b1);
        `CHK("phase", 12'h001, phase_count)
        count_lit();
        `CHK("lit4", 1, c4)
        `CHK("lit5", 4095, c5)
        lbp_host_model_inst.wr(LBP_ADDR_CH4_DIMMING, 16'h0000);
        count_lit();
        `CHK("lit4", 0, c4)
        $display("test duty done");
    endtask : t_duty
    // fade creeps from off; clearing fade jumps at once
    task automatic t_fade();
        lbp_host_model_inst.wr(LBP_ADDR_CH4_DIMMING, 16'h1FFF);
        count_lit();
        `CHK("fade slow", 1'b1, c4 < 3)
        lbp_host_model_inst.wr(LBP_ADDR_CH4_DIMMING, 16'h0FFF);
        count_lit();
        `CHK("fade off", 4095, c4)
        // fading down from full moves at most two steps in one window
        lbp_host_model_inst.wr(LBP_ADDR_CH4_DIMMING, 16'h1000);
        count_lit();
        `CHK("fade down", 1'b1, c4 > 4092)
        $display("test fade done");
    endtask : t_fade
    // counts and verdict, then stop
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    // reset for 20 cycles, then the tests
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_config();
        t_duty();
        t_fade();
        summarize();
    end
endmodule : led_bypass_pwm_channels_tb
`default_nettype wire

// >>> rtl/lbp_channel.sv
// one dimming channel: applied duty, optional fade, and the lit compare
`timescale 1ns/1ns
`default_nettype none

module lbp_channel
    import lbp_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // programmed settings from the dimming register
    input  wire logic [11:0] duty_target,
    input  wire logic        fade_enable,
    // shared phase timing
    input  wire logic        run_enable,
    input  wire logic [11:0] phase,
    input  wire logic        period_end,
    // results
    output logic      [11:0] duty_applied,
    output logic             led_lit
);

    logic [11:0] duty_r;       // duty actually compared against the phase
    logic [11:0] duty_nxt;
    logic        lit_r;        // registered lit level, avoids compare glitches
    logic        lit_nxt;
    wire         below_w;      // applied duty still above target
    wire         above_w;      // applied duty still below target

    assign below_w = duty_r > duty_target;
    assign above_w = duty_r < duty_target;

    // with fade off the new duty applies at once; with fade on it walks
    // one step per period so a period never sees a torn compare value
    always_comb begin
        duty_nxt = duty_r;
        if (!fade_enable) begin
            duty_nxt = duty_target;
        end else if (period_end && above_w) begin
            duty_nxt = duty_r + LBP_FADE_STEP;
        end else if (period_end && below_w) begin
            duty_nxt = duty_r - LBP_FADE_STEP;
        end
    end

    // lit while running and phase is below duty: 0 never lights, 0xFFF always does
    // because the phase never reaches 0xFFF
    assign lit_nxt = run_enable && (phase < duty_r);

    // applied duty and lit output registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_r <= LBP_DUTY_RESET;
            lit_r  <= 1'b0;
        end else begin
            duty_r <= duty_nxt;
            lit_r  <= lit_nxt;
        end
    end

    assign duty_applied = duty_r;
    assign led_lit      = lit_r;

endmodule : lbp_channel

`default_nettype wire

// >>> rtl/lbp_pkg.sv
// constants shared by the led bypass pwm channel block
package lbp_pkg;

    // register addresses on the serial link register space
    localparam logic [7:0]  LBP_ADDR_SWITCH_CONFIG = 8'h02;
    localparam logic [7:0]  LBP_ADDR_CH4_DIMMING   = 8'h21;
    localparam logic [7:0]  LBP_ADDR_CH5_DIMMING   = 8'h22;

    // register widths as seen on the register port
    localparam int          LBP_REG_W              = 16;
    localparam int          LBP_DUTY_W             = 12;

    // dimming register field layout
    localparam int          LBP_DUTY_LSB           = 0;
    localparam int          LBP_DUTY_MSB           = 11;
    localparam int          LBP_FADE_BIT           = 12;

    // reset values
    localparam logic [15:0] LBP_CONFIG_RESET       = 16'h0000;
    localparam logic [11:0] LBP_DUTY_RESET         = 12'h000;
    localparam logic        LBP_FADE_RESET         = 1'b0;

    // phase counter runs 0 .. LBP_PHASE_LAST, so one period is 4095 steps
    localparam logic [11:0] LBP_PHASE_RESET        = 12'h000;
    localparam logic [11:0] LBP_PHASE_LAST         = 12'hFFE;

    // fade moves the applied duty by this much once per pwm period
    localparam logic [11:0] LBP_FADE_STEP          = 12'h001;

endpackage : lbp_pkg

// >>> rtl/lbp_pwm_top.sv
// led bypass pwm channels four and five with config register and phase clock
`timescale 1ns/1ns
`default_nettype none

module lbp_pwm_top
    import lbp_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port from the serial link decoder, same clock
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    // global switch run enable level, held in a register elsewhere
    input  wire logic        switch_run_enable,
    // configuration contents for slew, clock choice and short thresholds
    output logic      [15:0] switch_config,
    output logic             config_write_refused,
    // channel outputs, high keeps the led lit, low closes the bypass
    output logic             led4_lit,
    output logic             led5_lit,
    output logic             bypass4_closed,
    output logic             bypass5_closed,
    // phase count for observation
    output logic      [11:0] phase_count
);

    // address match helper, used by both the write and the read decode
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
        addr_is = (a == ref_a);
    endfunction : addr_is

    // pack a dimming register for read back; bits above the fade bit read zero
    function automatic logic [15:0] pack_dim(input logic fade, input logic [11:0] duty);
        pack_dim = {3'b000, fade, duty};
    endfunction : pack_dim

    // stored register contents
    logic [15:0] config_r;          // switch configuration
    logic [11:0] ch4_duty_r;        // channel four duty
    logic        ch4_fade_r;        // channel four fade enable
    logic [11:0] ch5_duty_r;        // channel five duty
    logic        ch5_fade_r;        // channel five fade enable
    logic [15:0] rdata_r;           // read data, held until the next read
    logic        rvalid_r;          // one cycle pulse after a read request
    logic        refused_r;         // one cycle pulse on a blocked config write

    // phase clock state
    logic [11:0] phase_r;
    logic [11:0] phase_nxt;
    logic        run_d_r;           // previous run level for edge detection

    // decoded strobes
    wire         hit_cfg_w;
    wire         hit_ch4_w;
    wire         hit_ch5_w;
    wire         wr_cfg_ok_w;
    wire         wr_cfg_bad_w;
    wire         wr_ch4_w;
    wire         wr_ch5_w;
    wire         run_rise_w;
    wire         period_end_w;
    wire  [15:0] rd_mux_w;
    wire         lit4_w;
    wire         lit5_w;

    // address decode shared by writes and reads
    assign hit_cfg_w = addr_is(reg_addr, LBP_ADDR_SWITCH_CONFIG);
    assign hit_ch4_w = addr_is(reg_addr, LBP_ADDR_CH4_DIMMING);
    assign hit_ch5_w = addr_is(reg_addr, LBP_ADDR_CH5_DIMMING);

    // config writes pass only while switches are stopped; a write during
    // run would change slew or clock under a live pwm, so it is dropped
    // and flagged instead of half applied
    assign wr_cfg_ok_w  = reg_wr && hit_cfg_w && !switch_run_enable;
    assign wr_cfg_bad_w = reg_wr && hit_cfg_w && switch_run_enable;
    assign wr_ch4_w     = reg_wr && hit_ch4_w;
    assign wr_ch5_w     = reg_wr && hit_ch5_w;

    // read selection; unmapped addresses return zero
    assign rd_mux_w = hit_cfg_w ? config_r :
                      hit_ch4_w ? pack_dim(ch4_fade_r, ch4_duty_r) :
                      hit_ch5_w ? pack_dim(ch5_fade_r, ch5_duty_r) :
                      16'h0000;

    // configuration register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_r <= LBP_CONFIG_RESET;
        end else if (wr_cfg_ok_w) begin
            config_r <= reg_wdata;
        end
    end

    // channel four dimming register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch4_duty_r <= LBP_DUTY_RESET;
            ch4_fade_r <= LBP_FADE_RESET;
        end else if (wr_ch4_w) begin
            ch4_duty_r <= reg_wdata[LBP_DUTY_MSB:LBP_DUTY_LSB];
            ch4_fade_r <= reg_wdata[LBP_FADE_BIT];
        end
    end

    // channel five dimming register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch5_duty_r <= LBP_DUTY_RESET;
            ch5_fade_r <= LBP_FADE_RESET;
        end else if (wr_ch5_w) begin
            ch5_duty_r <= reg_wdata[LBP_DUTY_MSB:LBP_DUTY_LSB];
            ch5_fade_r <= reg_wdata[LBP_FADE_BIT];
        end
    end

    // read answer one cycle after the request, data held until next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rd_mux_w;
            end
        end
    end

    // refused write flag, one cycle per blocked write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refused_r <= 1'b0;
        end else begin
            refused_r <= wr_cfg_bad_w;
        end
    end

    // run edge: the phase starts at its reset value on the first run
    // cycle, so devices enabled by one broadcast packet stay in step
    assign run_rise_w   = switch_run_enable && !run_d_r;
    assign period_end_w = switch_run_enable && (phase_r == LBP_PHASE_LAST);

    // phase counter next value
    always_comb begin
        phase_nxt = phase_r + 12'h001;
        if (!switch_run_enable) begin
            phase_nxt = LBP_PHASE_RESET;
        end else if (run_rise_w) begin
            phase_nxt = LBP_PHASE_RESET + 12'h001;
        end else if (period_end_w) begin
            phase_nxt = LBP_PHASE_RESET;
        end
    end

    // phase counter and run history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= LBP_PHASE_RESET;
            run_d_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            run_d_r <= switch_run_enable;
        end
    end

    // channel four compare and fade
    lbp_channel u_ch4 (
        .clk          (clk),
        .rst_n        (rst_n),
        .duty_target  (ch4_duty_r),
        .fade_enable  (ch4_fade_r),
        .run_enable   (switch_run_enable),
        .phase        (phase_r),
        .period_end   (period_end_w),
        .duty_applied (),
        .led_lit      (lit4_w)
    );

    // channel five compare and fade
    lbp_channel u_ch5 (
        .clk          (clk),
        .rst_n        (rst_n),
        .duty_target  (ch5_duty_r),
        .fade_enable  (ch5_fade_r),
        .run_enable   (switch_run_enable),
        .phase        (phase_r),
        .period_end   (period_end_w),
        .duty_applied (),
        .led_lit      (lit5_w)
    );

    // outputs; the bypass closes whenever the led is not lit
    assign reg_rdata            = rdata_r;
    assign reg_rvalid           = rvalid_r;
    assign switch_config        = config_r;
    assign config_write_refused = refused_r;
    assign led4_lit             = lit4_w;
    assign led5_lit             = lit5_w;
    assign bypass4_closed       = !lit4_w;
    assign bypass5_closed       = !lit5_w;
    assign phase_count          = phase_r;

endmodule : lbp_pwm_top

`default_nettype wire
